// ==== rtl/bid_pkg.sv ====
// package for the baseline twelve-bit instruction decoder block
// assumes a single 100 MHz clock; register map is byte addressed on an Avalon-MM slave
package bid_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int OSC_PER_CYCLE = 4;                 // oscillator periods per instruction cycle
   localparam logic [1:0] Q_LAST = 2'(OSC_PER_CYCLE - 1);

   // ---------------------------------------------------------------
   // bus register map (byte offsets)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_INSTR = 8'h00;         // write: execute one instruction word
   localparam logic [7:0] OFS_ACC = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_PC = 8'h0C;
   localparam logic [7:0] OFS_PORT = 8'h10;          // read: {port_direction_load, latch, pins}
   localparam logic [7:0] OFS_OPTION = 8'h14;
   localparam int FILE_WIN_BIT = 7;                  // 0x80..0xFC: raw file array window

   // ---------------------------------------------------------------
   // status and option fields, special file addresses
   // ---------------------------------------------------------------
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_PD = 3;
   localparam int ST_TO = 4;
   localparam int OPT_PSA = 3;                       // 1: prescaler on watchdog, 0: on timer
   localparam logic [4:0] FA_TIMER = 5'h01;
   localparam logic [4:0] FA_PCL = 5'h02;
   localparam logic [4:0] FA_STATUS = 5'h03;
   localparam logic [4:0] FA_PORT = 5'h06;
   localparam logic [2:0] PORT_DIRECTION_LOAD_SECOND_PORT = 3'h6;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_STATUS = 8'h18;
   localparam logic [7:0] RST_OPTION = 8'hFF;
   localparam logic [7:0] RST_PORT_DIRECTION_LOAD = 8'hFF;
   localparam logic [10:0] RST_PC = 11'h000;

   // ---------------------------------------------------------------
   // opcodes: byte ops by bits 11:6, others by bits 11:8
   // ---------------------------------------------------------------
   localparam logic [5:0] OP_MISC = 6'h00;
   localparam logic [5:0] OP_CLR = 6'h01;
   localparam logic [5:0] OP_SUB = 6'h02;
   localparam logic [5:0] OP_DEC = 6'h03;
   localparam logic [5:0] OP_OR = 6'h04;
   localparam logic [5:0] OP_AND = 6'h05;
   localparam logic [5:0] OP_XOR = 6'h06;
   localparam logic [5:0] OP_ADD = 6'h07;
   localparam logic [5:0] OP_MOV = 6'h08;
   localparam logic [5:0] OP_COM = 6'h09;
   localparam logic [5:0] OP_INC = 6'h0A;
   localparam logic [5:0] OP_DECSZ = 6'h0B;
   localparam logic [5:0] OP_RRC = 6'h0C;
   localparam logic [5:0] OP_RLC = 6'h0D;
   localparam logic [5:0] OP_SWAP = 6'h0E;
   localparam logic [5:0] OP_INCSZ = 6'h0F;
   localparam logic [3:0] OP_BCLR = 4'h4;
   localparam logic [3:0] OP_BSET = 4'h5;
   localparam logic [3:0] OP_SKIP_LOW = 4'h6;
   localparam logic [3:0] OP_SKIP_HIGH = 4'h7;
   localparam logic [3:0] OP_RET = 4'h8;
   localparam logic [3:0] OP_CALL = 4'h9;
   localparam logic [3:0] OP_JUMP_A = 4'hA;
   localparam logic [3:0] OP_JUMP_B = 4'hB;
   localparam logic [3:0] OP_LOADL = 4'hC;
   localparam logic [3:0] OP_ORL = 4'hD;
   localparam logic [3:0] OP_ANDL = 4'hE;
   localparam logic [3:0] OP_XORL = 4'hF;
   localparam logic [4:0] MISC_NOP = 5'h00;
   localparam logic [4:0] MISC_OPTION = 5'h02;
   localparam logic [4:0] MISC_SLEEP = 5'h03;
   localparam logic [4:0] MISC_WDT = 5'h04;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      bid_idle = 3'h1,
      bid_exec = 3'h2,
      bid_resp = 3'h4
   } bid_fsm_t;

   typedef struct packed {
      logic [7:0] latch;
      logic [7:0] port_direction_load;
   } bid_port_t;

   typedef struct packed {
      bid_fsm_t fsm;
      logic second;                                  // in second instruction cycle
      logic [1:0] qcnt;
      logic [11:0] instr;
      logic [7:0] acc;
      logic [7:0] status;
      logic [7:0] option;
      logic [10:0] pc;
      logic [1:0][10:0] stack;
      logic [31:0][7:0] file;
      bid_port_t port;
      logic waitrequest;
      logic [31:0] readdata;
      logic presc_clr;
      logic wdt_clr;
      logic standby;
   } bid_state_t;

endpackage

// ==== rtl/bid_core.sv ====
// instruction decoder and executor for a twelve-bit instruction word core
// assumes instruction words arrive as Avalon-MM writes; pins sampled synchronous to i_clock
//
// Overview of operation
// RL1 - add and file-minus-accumulator update carry, nibble carry and zero
// RL2 - and, or, xor with file register update only zero
// RL3 - destination bit 0 writes accumulator, 1 writes the file register
// RL4 - decrement or increment, skip next when zero, two cycles, no flags; here two cycles only when the skip is taken, one otherwise
// RL5 - rotate left or right through carry, only carry changes
// RL6 - clear or set the selected bit in one cycle, no flags
// RL7 - test bit, skip when clear or set, skip costs one extra cycle
// RL8 - and literal into accumulator, updates zero
// RL9 - or, xor literal update zero; load literal changes no flag
// RL10 - counter bit 8 cleared on call and on writes to the counter file register; absolute jump and return load it
// RL11 - return loads literal into accumulator, two cycles, no flags
// RL12 - watchdog kick, one cycle, sets timeout and sleep flags
// RL13 - standby entry, one cycle, sets timeout, clears sleep flag
// RL14 - accumulator copied to direction latches of port six; 1 disables driver
// RL15 - read-modify-write of the port uses pin levels, not latches
// RL16 - writes to timer register clear prescaler when assigned to timer
// RL17 - accumulator clear loads zero and sets zero flag
// RL18 - call pushes return, loads literal, page bits from status, two cycles
// RL19 - move, complement, increment, decrement set zero; swap no flag
// RL20 - all-zero is no-op; option load; store accumulator to file
// RL21 - all other instructions take one cycle of four clocks; absolute jumps and writes to the counter file register take two here
`timescale 1ns/100ps
`default_nettype none

module bid_core (
   input wire logic i_clock,                  // 100 MHz clock
   input wire logic i_rst_n,                  // async reset, active low
   input wire logic [7:0] i_avs_address,      // byte address
   input wire logic i_avs_read,               // read request
   input wire logic i_avs_write,              // write request
   input wire logic [31:0] i_avs_writedata,   // write data
   output logic [31:0] o_avs_readdata,        // read data
   output logic o_avs_waitrequest,            // stall until answer
   input wire logic [7:0] i_port_pins,        // levels sensed on the second port
   output logic [7:0] o_port_latch,           // second port output latch
   output logic [7:0] o_port_port_direction_load,            // second port direction, 1 = input
   output logic [7:0] o_option,               // option register
   output logic o_prescaler_clear,            // one-cycle pulse
   output logic o_watchdog_clear,             // one-cycle pulse
   output logic o_standby_req                 // one-cycle pulse
);

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   // two flops so the release is clean relative to i_clock
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // file read as seen by instructions: pins for the port, live counter and status
   function automatic logic [7:0] file_read(input bid_pkg::bid_state_t st, input logic [4:0] a,
                                            input logic [7:0] pins);
      case (a)
         bid_pkg::FA_PCL: file_read = st.pc[7:0];
         bid_pkg::FA_STATUS: file_read = st.status;
         bid_pkg::FA_PORT: file_read = pins; // RL15
         default: file_read = st.file[a];
      endcase
   endfunction

   // bus read decode
   function automatic logic [31:0] bus_read(input bid_pkg::bid_state_t st, input logic [7:0] a,
                                            input logic [7:0] pins);
      bus_read = 32'h0000_0000;
      if (a[bid_pkg::FILE_WIN_BIT]) begin
         bus_read = {24'h00_0000, st.file[a[6:2]]};
      end else begin
         case (a)
            bid_pkg::OFS_ACC: bus_read = {24'h00_0000, st.acc};
            bid_pkg::OFS_STATUS: bus_read = {24'h00_0000, st.status};
            bid_pkg::OFS_PC: bus_read = {21'h00_0000, st.pc};
            bid_pkg::OFS_PORT: bus_read = {8'h00, st.port.port_direction_load, st.port.latch, pins};
            bid_pkg::OFS_OPTION: bus_read = {24'h00_0000, st.option};
            bid_pkg::OFS_INSTR: bus_read = {20'h0_0000, st.instr};
            default: bus_read = 32'h0000_0000;
         endcase
      end
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   bid_pkg::bid_state_t s;
   bid_pkg::bid_state_t next_s;
   bid_pkg::bid_state_t e;          // state after the held instruction
   logic [11:0] ins;
   logic [4:0] fa;
   logic [7:0] fv;
   logic [7:0] res;
   logic [8:0] wide;
   logic [4:0] nib;
   logic wf;
   logic upd_z;
   logic two;
   logic commit;

   // ---------------------------------------------------------------
   // execution of the held instruction word
   // ---------------------------------------------------------------
   // the whole result is formed from stable state; it is only taken at the last clock
   always_comb begin
      e = s;
      e.presc_clr = 1'b0;
      e.wdt_clr = 1'b0;
      e.standby = 1'b0;
      ins = s.instr;
      fa = ins[4:0];
      fv = file_read(s, fa, i_port_pins);
      res = fv;
      wide = 9'h000;
      nib = 5'h00;
      wf = 1'b0;
      upd_z = 1'b0;
      two = 1'b0;
      e.pc = s.pc + 11'h001;
      if (ins[11:10] == 2'h0) begin
         // byte ops: result goes where bit 5 says
         upd_z = 1'b1;
         case (ins[11:6])
            bid_pkg::OP_MISC: begin
               upd_z = 1'b0;
               if (ins[5]) begin
                  res = s.acc; // RL20
                  wf = 1'b1;
               end else begin
                  case (ins[4:0])
                     bid_pkg::MISC_OPTION: e.option = s.acc; // RL20
                     bid_pkg::MISC_SLEEP: begin
                        e.status[bid_pkg::ST_TO] = 1'b1; // RL13
                        e.status[bid_pkg::ST_PD] = 1'b0; // RL13
                        e.standby = 1'b1;
                     end
                     bid_pkg::MISC_WDT: begin
                        e.status[bid_pkg::ST_TO] = 1'b1; // RL12
                        e.status[bid_pkg::ST_PD] = 1'b1; // RL12
                        e.wdt_clr = 1'b1;
                        e.presc_clr = s.option[bid_pkg::OPT_PSA];
                     end
                     default: begin
                        if (ins[4:0] == {2'h0, bid_pkg::PORT_DIRECTION_LOAD_SECOND_PORT}) begin
                           e.port.port_direction_load = s.acc; // RL14
                        end
                     end
                  endcase
               end
            end
            bid_pkg::OP_CLR: res = 8'h00; // RL17
            bid_pkg::OP_SUB: begin
               wide = {1'b0, fv} - {1'b0, s.acc};
               nib = {1'b0, fv[3:0]} - {1'b0, s.acc[3:0]};
               res = wide[7:0];
               e.status[bid_pkg::ST_C] = ~wide[8]; // RL1
               e.status[bid_pkg::ST_DC] = ~nib[4]; // RL1
            end
            bid_pkg::OP_DEC: res = fv - 8'h01; // RL19
            bid_pkg::OP_OR: res = s.acc | fv; // RL2
            bid_pkg::OP_AND: res = s.acc & fv; // RL2
            bid_pkg::OP_XOR: res = s.acc ^ fv; // RL2
            bid_pkg::OP_ADD: begin
               wide = {1'b0, fv} + {1'b0, s.acc};
               nib = {1'b0, fv[3:0]} + {1'b0, s.acc[3:0]};
               res = wide[7:0];
               e.status[bid_pkg::ST_C] = wide[8]; // RL1
               e.status[bid_pkg::ST_DC] = nib[4]; // RL1
            end
            bid_pkg::OP_MOV: res = fv; // RL19
            bid_pkg::OP_COM: res = ~fv; // RL19
            bid_pkg::OP_INC: res = fv + 8'h01; // RL19
            bid_pkg::OP_DECSZ, bid_pkg::OP_INCSZ: begin
               upd_z = 1'b0;
               res = (ins[8]) ? fv + 8'h01 : fv - 8'h01; // RL4
               two = (res == 8'h00); // RL4
            end
            bid_pkg::OP_RRC, bid_pkg::OP_RLC: begin
               upd_z = 1'b0;
               res = (ins[6]) ? {fv[6:0], s.status[bid_pkg::ST_C]} : {s.status[bid_pkg::ST_C], fv[7:1]}; // RL5
               e.status[bid_pkg::ST_C] = (ins[6]) ? fv[7] : fv[0]; // RL5
            end
            default: begin
               upd_z = 1'b0;
               res = {fv[3:0], fv[7:4]}; // RL19
            end
         endcase
         if (ins[11:6] != bid_pkg::OP_MISC) begin
            if (ins[5]) begin
               wf = 1'b1; // RL3
            end else begin
               e.acc = res; // RL3
            end
         end
      end else begin
         case (ins[11:8])
            bid_pkg::OP_BCLR, bid_pkg::OP_BSET: begin
               res[ins[7:5]] = ins[8]; // RL6
               wf = 1'b1;
            end
            bid_pkg::OP_SKIP_LOW, bid_pkg::OP_SKIP_HIGH: two = (fv[ins[7:5]] == ins[8]); // RL7
            bid_pkg::OP_RET: begin
               e.acc = ins[7:0]; // RL11
               e.pc = s.stack[0];
               e.stack[0] = s.stack[1];
               two = 1'b1; // RL11
            end
            bid_pkg::OP_CALL: begin
               e.stack[1] = s.stack[0];
               e.stack[0] = s.pc + 11'h001; // RL18
               e.pc = {s.status[6:5], 1'b0, ins[7:0]}; // RL18 RL10
               two = 1'b1; // RL18
            end
            bid_pkg::OP_JUMP_A, bid_pkg::OP_JUMP_B: begin
               e.pc = {s.status[6:5], ins[8:0]}; // RL10
               two = 1'b1; // RL10
            end
            bid_pkg::OP_LOADL: e.acc = ins[7:0]; // RL9
            bid_pkg::OP_ORL: begin
               e.acc = s.acc | ins[7:0]; // RL9
               upd_z = 1'b1;
            end
            bid_pkg::OP_ANDL: begin
               e.acc = s.acc & ins[7:0]; // RL8
               upd_z = 1'b1;
            end
            default: begin
               e.acc = s.acc ^ ins[7:0]; // RL9
               upd_z = 1'b1;
            end
         endcase
         if (ins[11:8] >= bid_pkg::OP_LOADL) begin
            res = e.acc;
         end
      end
      // skips replace the next fetch by a no-op: counter steps by two
      if (two && (ins[11:10] != 2'h2)) begin
         e.pc = s.pc + 11'h002; // RL4 RL7
      end
      // file write-back with the special addresses
      if (wf) begin
         case (fa)
            bid_pkg::FA_PCL: begin
               e.pc = {s.status[6:5], 1'b0, res}; // RL10
               two = 1'b1;
            end
            bid_pkg::FA_STATUS: e.status = {res[7:5], s.status[4:3], res[2:0]};
            bid_pkg::FA_PORT: e.port.latch = res;
            bid_pkg::FA_TIMER: begin
               e.file[fa] = res;
               e.presc_clr = ~s.option[bid_pkg::OPT_PSA]; // RL16
            end
            default: e.file[fa] = res;
         endcase
      end
      // the zero flag update wins over a direct write to status; carry and nibble carry do not
      if (upd_z) begin
         e.status[bid_pkg::ST_Z] = (res == 8'h00); // RL2 RL8 RL17
      end
   end

   // ---------------------------------------------------------------
   // bus slave and instruction cycle sequencing
   // ---------------------------------------------------------------
   assign commit = (s.fsm == bid_pkg::bid_exec) && (s.qcnt == 2'h0) && (!two || s.second);

   // waitrequest is registered, so every access takes at least one stall cycle
   always_comb begin
      next_s = s;
      next_s.presc_clr = 1'b0;
      next_s.wdt_clr = 1'b0;
      next_s.standby = 1'b0;
      case (s.fsm)
         bid_pkg::bid_idle: begin
            next_s.waitrequest = 1'b1;
            if (i_avs_write && (i_avs_address == bid_pkg::OFS_INSTR)) begin
               next_s.instr = i_avs_writedata[11:0];
               next_s.fsm = bid_pkg::bid_exec;
               next_s.qcnt = bid_pkg::Q_LAST; // RL21
               next_s.second = 1'b0;
            end else if (i_avs_read || i_avs_write) begin
               next_s.readdata = bus_read(s, i_avs_address, i_port_pins);
               next_s.waitrequest = 1'b0;
               next_s.fsm = bid_pkg::bid_resp;
            end
         end
         bid_pkg::bid_exec: begin
            if (s.qcnt != 2'h0) begin
               next_s.qcnt = s.qcnt - 2'h1;
            end else if (!commit) begin
               next_s.second = 1'b1; // RL4 RL7 RL10 RL11 RL18
               next_s.qcnt = bid_pkg::Q_LAST;
            end else begin
               next_s = e;
               next_s.fsm = bid_pkg::bid_resp;
               next_s.waitrequest = 1'b0;
               next_s.readdata = 32'h0000_0000;
            end
         end
         bid_pkg::bid_resp: begin
            // the master samples waitrequest low here; writes land on this edge
            next_s.waitrequest = 1'b1;
            next_s.fsm = bid_pkg::bid_idle;
            if (i_avs_write && i_avs_address[bid_pkg::FILE_WIN_BIT]) begin
               next_s.file[i_avs_address[6:2]] = i_avs_writedata[7:0];
            end else if (i_avs_write) begin
               case (i_avs_address)
                  bid_pkg::OFS_ACC: next_s.acc = i_avs_writedata[7:0];
                  bid_pkg::OFS_STATUS: next_s.status = i_avs_writedata[7:0];
                  bid_pkg::OFS_PC: next_s.pc = i_avs_writedata[10:0];
                  bid_pkg::OFS_OPTION: next_s.option = i_avs_writedata[7:0];
                  default: next_s.acc = s.acc;
               endcase
            end
         end
         default: begin
            next_s.fsm = bid_pkg::bid_idle;
            next_s.waitrequest = 1'b1;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.fsm <= bid_pkg::bid_idle;
         s.waitrequest <= 1'b1;
         s.status <= bid_pkg::RST_STATUS;
         s.option <= bid_pkg::RST_OPTION;
         s.port.port_direction_load <= bid_pkg::RST_PORT_DIRECTION_LOAD;
         s.pc <= bid_pkg::RST_PC;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state flops
   assign o_avs_readdata = s.readdata;
   assign o_avs_waitrequest = s.waitrequest;
   assign o_port_latch = s.port.latch;
   assign o_port_port_direction_load = s.port.port_direction_load;
   assign o_option = s.option;
   assign o_prescaler_clear = s.presc_clr;
   assign o_watchdog_clear = s.wdt_clr;
   assign o_standby_req = s.standby;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   int exec_len;

   // counts clocks spent in execution for the cycle-length check
   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         exec_len <= 0;
      end else if (s.fsm == bid_pkg::bid_exec) begin
         exec_len <= exec_len + 1;
      end else begin
         exec_len <= 0;
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!rst_n);

   a_cycle_length: assert property (commit |-> exec_len == (two ? 7 : 3)) // RL21
      else $error("instruction length wrong");
   a_add_result: assert property (commit && ins[11:6] == bid_pkg::OP_ADD && !ins[5] // RL1
      |=> s.acc == 8'($past(s.acc) + $past(fv)))
      else $error("add result wrong");
   a_logic_carry_kept: assert property (commit && ins[11:8] == 4'h1 && ins[7:6] != 2'h3 // RL2
      |=> s.status[1:0] == $past(s.status[1:0]))
      else $error("logic op touched carry");
   a_dest_file: assert property (commit && ins[11:10] == 2'h0 && ins[11:6] != bid_pkg::OP_MISC && ins[5] // RL3
      |=> $stable(s.acc))
      else $error("file destination changed accumulator");
   a_rotate_carry: assert property (commit && ins[11:6] == bid_pkg::OP_RLC // RL5
      |=> s.status[bid_pkg::ST_C] == $past(fv[7]))
      else $error("rotate carry wrong");
   a_literal_and: assert property (commit && ins[11:8] == bid_pkg::OP_ANDL // RL8
      |=> s.acc == ($past(s.acc) & $past(ins[7:0])))
      else $error("literal and wrong");
   a_jump_target: assert property (commit && ins[11:9] == 3'h5 // RL10
      |=> s.pc == {$past(s.status[6:5]), $past(ins[8:0])})
      else $error("jump target wrong");
   a_wdt_flags: assert property (commit && ins == 12'h004 // RL12
      |=> s.status[4:3] == 2'h3 && o_watchdog_clear ##1 !o_watchdog_clear)
      else $error("watchdog kick flags wrong");
   a_bus_answer: assert property ($rose(s.fsm == bid_pkg::bid_resp) |-> !o_avs_waitrequest ##1 o_avs_waitrequest)
      else $error("answer not one cycle");

   c_skip_taken: cover property (commit && two && ins[11:9] == 3'h3);
   c_call: cover property (commit && ins[11:8] == bid_pkg::OP_CALL);
   c_port_dir: cover property (commit && ins == 12'h006);

endmodule

`default_nettype wire

// ==== test/bid_prog_mem.sv ====
// program memory model: twelve-bit words for the decoder
// assumes a word index settled one edge before it is used
`timescale 1ns/100ps
`default_nettype none
module bid_prog_mem (
   input wire logic [4:0] i_addr, // word index
   output logic [11:0] o_word     // instruction word
);
   // fixed program; words beyond it read as no-op
   always_comb begin
      case (i_addr)
         5'h00: o_word = 12'hC55;
         5'h01: o_word = 12'hD0A;
         5'h02: o_word = 12'hF0F;
         5'h03: o_word = 12'hE30;
         5'h04: o_word = 12'h1E8;
         5'h05: o_word = 12'h040;
         5'h06: o_word = 12'h5E8;
         5'h07: o_word = 12'h408;
         5'h08: o_word = 12'h7E8;
         5'h09: o_word = 12'h6E8;
         5'h0A: o_word = 12'h206;
         5'h0B: o_word = 12'h006;
         5'h0C: o_word = 12'h026;
         5'h0D: o_word = 12'h1C8;
         5'h0E: o_word = 12'h0A8;
         5'h0F: o_word = 12'h348;
         5'h10: o_word = 12'h168;
         5'h11: o_word = 12'h188;
         5'h12: o_word = 12'h930;
         5'h13: o_word = 12'h8A5;
         5'h14: o_word = 12'hB23;
         5'h15: o_word = 12'h2E9;
         5'h16: o_word = 12'h004;
         5'h17: o_word = 12'h003;
         5'h18: o_word = 12'h002;
         5'h19: o_word = 12'h021;
         default: o_word = 12'h000;
      endcase
   end
endmodule
`default_nettype wire

// ==== test/bid_core_tb_top.sv ====
// bench for the instruction decoder: bus driver plus read watcher
// assumes bid_core as bus slave, bid_prog_mem as word source
`timescale 1ns/100ps
`default_nettype none
module bid_core_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic wait_r;
   logic [7:0] pins = 8'h00;
   logic [4:0] pidx = 5'h00;
   logic [11:0] word;
   logic [31:0] exp_q[$];
   logic [31:0] seen;
   logic [7:0] exp_opt = bid_pkg::RST_OPTION;
   logic [7:0] exp_port_direction_load = bid_pkg::RST_PORT_DIRECTION_LOAD;
   logic [7:0] exp_latch = 8'h00;
   wire [7:0] opt_o;
   wire [7:0] port_direction_load_o;
   wire [7:0] latch_o;
   wire [2:0] pulse;
   int bad_count = 0;
   int comparisons = 0;
   int cyc = 0;
   logic [7:0] accs [6] = '{8'h55, 8'h5F, 8'h50, 8'h10, 8'h10, 8'h00};

   initial begin
      forever #5 clk = ~clk;
   end

   bid_core u_dut (.i_clock(clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r),
      .i_port_pins(pins), .o_port_latch(latch_o), .o_port_port_direction_load(port_direction_load_o), .o_option(opt_o),
      .o_prescaler_clear(pulse[2]), .o_watchdog_clear(pulse[1]), .o_standby_req(pulse[0]));
   bid_prog_mem u_mem (.i_addr(pidx), .o_word(word));

   // one transfer held until waitrequest low; a read notes d as expectation
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= ~w;
      if (!w) begin
         exp_q.push_back(d);
      end
      @(posedge clk);
      while (wait_r !== 1'b0) begin
         @(posedge clk);
      end
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask

   // fetch a word; one edge lets the index settle before the write
   // notes the expected output pins and pulses p = {prescaler, watchdog, standby}
   task automatic run(input logic [4:0] i, input logic [2:0] p = 3'h0);
      pidx <= i;
      exp_q.push_back({exp_opt, exp_port_direction_load, exp_latch, 5'h00, p});
      @(posedge clk);
      bus(1'b1, 8'h00, {20'h0_0000, word});
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // watcher: each read or instruction answer against the oldest note
   always @(posedge clk) begin
      if ((rd || (wr && addr == 8'h00)) && wait_r === 1'b0 && exp_q.size() > 0) begin
         seen = rd ? rdata : {opt_o, port_direction_load_o, latch_o, 5'h00, pulse};
         comparisons++;
         if (seen !== exp_q[0]) begin
            bad_count++;
            $display("[ERR] access %h expected %h seen %h", addr, exp_q[0], seen);
         end
         void'(exp_q.pop_front());
      end
   end

   // hang guard: the whole run needs well under this
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         results();
      end
   end

   initial begin
      void'($urandom(11084));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      bus(1'b0, 8'h08, 32'h0000_0018);
      $display("test reset done");
      bus(1'b1, 8'hA0, 32'h0000_000F);
      for (int i = 0; i < 6; i++) begin
         run(5'(i));
         bus(1'b0, 8'h04, {24'h00_0000, accs[i]});
      end
      bus(1'b0, 8'hA0, 32'h0000_001F);
      bus(1'b0, 8'h08, 32'h0000_001C);
      $display("test literal and add done");
      run(5'h06);
      run(5'h07);
      bus(1'b0, 8'hA0, 32'h0000_009E);
      bus(1'b1, 8'h0C, 32'h0000_0000);
      run(5'h08);
      bus(1'b0, 8'h0C, 32'h0000_0002);
      run(5'h09);
      bus(1'b0, 8'h0C, 32'h0000_0003);
      $display("test bit ops done");
      pins <= 8'($urandom);
      run(5'h0A);
      bus(1'b0, 8'h04, {24'h00_0000, pins});
      bus(1'b1, 8'h04, 32'h0000_003C);
      exp_port_direction_load = 8'h3C;
      run(5'h0B);
      bus(1'b0, 8'h10, {8'h00, 8'h3C, 8'h00, pins});
      $display("test port done");
      // store to port, add to acc, subtract, rotate, and, xor
      exp_latch = 8'h3C;
      for (int i = 12; i < 18; i++) begin
         run(5'(i));
      end
      bus(1'b0, 8'h04, 32'h0000_0008);
      bus(1'b0, 8'h08, 32'h0000_001B);
      bus(1'b0, 8'hA0, 32'h0000_0080);
      $display("test file ops done");
      bus(1'b1, 8'h0C, 32'h0000_0000);
      run(5'h12);
      bus(1'b0, 8'h0C, 32'h0000_0030);
      run(5'h13);
      run(5'h14);
      bus(1'b0, 8'h04, 32'h0000_00A5);
      bus(1'b0, 8'h0C, 32'h0000_0123);
      bus(1'b1, 8'hA4, 32'h0000_0001);
      run(5'h15);
      bus(1'b0, 8'h0C, 32'h0000_0125);
      $display("test control done");
      bus(1'b1, 8'h08, 32'h0000_0000);
      run(5'h16, 3'h6);
      run(5'h17, 3'h1);
      bus(1'b0, 8'h08, 32'h0000_0010);
      exp_opt = 8'hA5;
      run(5'h18);
      run(5'h19, 3'h4);
      $display("test standby and option done");
      results();
   end
endmodule
`default_nettype wire
